/* hw/scf_regs.sv */
// SPI slave and front configuration registers: soft reset, streaming address
// direction and hold, separate read output flag, power mode and maker code.
// Assumes the serial pins are asynchronous to clk and the serial clock runs
// at most one eighth of clk; mode 0 framing (sample on rise, shift on fall).
//
// Operation
// - Writing one to interface bit 7 resets the whole chip and every register.
// - The soft reset bit clears itself after the internal reset completes.
// - Bit 5, reset one, makes streaming addresses ascend; zero makes them descend.
// - Read data only on the separate output; bit 4 always reads one.
// - Power mode bits 1:0: zero normal, three full power down, others reserved.
// - Sixteen-bit read-only maker code at 0xC, never changed by writes.
// - Address hold bit 0 keeps streaming address fixed; zero defers to direction.
`timescale 1ns/1ps
`default_nettype none

module scf_regs #(
  parameter logic [15:0] MAKER_CODE = 16'hA5C3  // Arbitrary neutral value.
) (
  input  wire logic       clk,             // 100 MHz system clock.
  input  wire logic       rstn,            // Asynchronous reset, active low.
  input  wire logic       spi_sclk,        // Serial clock from host.
  input  wire logic       spi_csn,         // Chip select, active low.
  input  wire logic       spi_sdi,         // Serial data in.
  output var  logic       spi_sdo,         // Serial read data out.
  output var  logic       spi_sdo_oe,      // High while read data is driven.
  output var  logic       chip_soft_reset, // High while the internal reset runs.
  output var  logic [1:0] power_mode,      // Power mode field.
  output var  logic       full_power_down  // High in full power down.
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic       sclk_s1, sclk_s2, sclk_s3;
  logic       csn_s1, csn_s2;
  logic       sdi_s1, sdi_s2;
  logic       sclk_rise, sclk_fall;

  // Two flip-flops per pin, plus one delayed copy of the clock for edges.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      csn_s1  <= 1'b1;
      csn_s2  <= 1'b1;
      sdi_s1  <= 1'b0;
      sdi_s2  <= 1'b0;
    end else begin
      sclk_s1 <= spi_sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      csn_s1  <= spi_csn;
      csn_s2  <= csn_s1;
      sdi_s1  <= spi_sdi;
      sdi_s2  <= sdi_s1;
    end
  end

  assign sclk_rise = sclk_s2 & ~sclk_s3;
  assign sclk_fall = ~sclk_s2 & sclk_s3;

  // ---------------------------------------------------------------------------
  // Soft reset sequencer
  // ---------------------------------------------------------------------------
  logic [7:0] srst_cnt_reg;
  logic       srst_active;
  logic       wr_pulse_reg;
  logic [14:0] wr_addr_reg;
  logic [7:0] wr_data_reg;

  assign srst_active = (srst_cnt_reg != 8'h00);

  // Loads the hold count on a soft reset write and counts down to release.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      srst_cnt_reg <= 8'h00;
    end else if (srst_active) begin
      srst_cnt_reg <= srst_cnt_reg - 8'h01;
    end else if (wr_pulse_reg && wr_addr_reg == scf_pkg::ADDR_IF_CFG
                 && wr_data_reg[scf_pkg::BIT_SOFT_RESET]) begin
      srst_cnt_reg <= scf_pkg::SOFT_RESET_COUNT;
    end
  end

  assign chip_soft_reset = srst_active;

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------
  logic [7:0] if_cfg_reg;
  logic [7:0] pwr_cfg_reg;
  logic [7:0] usr_cfg_reg;

  // Byte writes land one cycle after the byte completes; soft reset restores all.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      if_cfg_reg  <= scf_pkg::RST_IF_CFG;
      pwr_cfg_reg <= scf_pkg::RST_PWR_CFG;
      usr_cfg_reg <= scf_pkg::RST_USR_CFG;
    end else if (srst_active) begin
      if_cfg_reg  <= scf_pkg::RST_IF_CFG;
      pwr_cfg_reg <= scf_pkg::RST_PWR_CFG;
      usr_cfg_reg <= scf_pkg::RST_USR_CFG;
    end else if (wr_pulse_reg) begin
      unique case (wr_addr_reg)
        scf_pkg::ADDR_IF_CFG: begin
          // Soft reset bit is not stored and bit 4 is fixed high.
          if_cfg_reg <= {1'b0, wr_data_reg[6:5], 1'b1, wr_data_reg[3:0]};
        end
        scf_pkg::ADDR_PWR_CFG: pwr_cfg_reg <= wr_data_reg;
        scf_pkg::ADDR_USR_CFG: usr_cfg_reg <= wr_data_reg;
        default: begin
          // Maker code and unmapped addresses ignore writes.
        end
      endcase
    end
  end

  assign power_mode      = pwr_cfg_reg[1:0];
  assign full_power_down = (pwr_cfg_reg[1:0] == scf_pkg::MODE_PWR_DOWN);

  // Read view of one byte; soft reset bit reads back the live reset state.
  function automatic logic [7:0] read_byte(input logic [14:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      scf_pkg::ADDR_IF_CFG:  v = {srst_active, if_cfg_reg[6:5], 1'b1, if_cfg_reg[3:0]};
      scf_pkg::ADDR_PWR_CFG: v = pwr_cfg_reg;
      scf_pkg::ADDR_ID_LO:   v = MAKER_CODE[7:0];
      scf_pkg::ADDR_ID_HI:   v = MAKER_CODE[15:8];
      scf_pkg::ADDR_USR_CFG: v = usr_cfg_reg;
      default:               v = 8'h00;
    endcase
    return v;
  endfunction : read_byte

  // ---------------------------------------------------------------------------
  // Serial frame engine
  // ---------------------------------------------------------------------------
  scf_pkg::scf_phase_t phase_reg;
  logic [4:0]  bit_cnt_reg;
  logic [15:0] shin_reg;
  logic [14:0] addr_reg;
  logic        is_read_reg;
  logic [7:0]  shout_reg;
  logic [14:0] addr_step;
  logic [14:0] instr_addr;
  logic        instr_read;

  // Next streaming address: hold wins, else direction bit decides.
  always_comb begin
    if (usr_cfg_reg[scf_pkg::BIT_ADDR_HOLD]) begin
      addr_step = addr_reg;
    end else if (if_cfg_reg[scf_pkg::BIT_ASCEND]) begin
      addr_step = addr_reg + 15'h0001;
    end else begin
      addr_step = addr_reg - 15'h0001;
    end
  end

  assign instr_addr = {shin_reg[13:0], sdi_s2};
  assign instr_read = shin_reg[scf_pkg::BIT_READ - 1];

  // Instruction capture, byte counting and address stepping.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_reg   <= scf_pkg::SCF_INSTR;
      bit_cnt_reg <= 5'h00;
      shin_reg    <= 16'h0000;
      addr_reg    <= 15'h0000;
      is_read_reg <= 1'b0;
    end else if (csn_s2 || srst_active) begin
      phase_reg   <= scf_pkg::SCF_INSTR;
      bit_cnt_reg <= 5'h00;
    end else if (sclk_rise) begin
      shin_reg <= {shin_reg[14:0], sdi_s2};
      unique case (phase_reg)
        scf_pkg::SCF_INSTR: begin
          if (bit_cnt_reg == scf_pkg::INSTR_LAST_BIT) begin
            phase_reg   <= scf_pkg::SCF_DATA;
            addr_reg    <= instr_addr;
            is_read_reg <= instr_read;
            bit_cnt_reg <= 5'h00;
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
          end
        end
        scf_pkg::SCF_DATA: begin
          if (bit_cnt_reg == scf_pkg::DATA_LAST_BIT) begin
            addr_reg    <= addr_step;
            bit_cnt_reg <= 5'h00;
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
          end
        end
      endcase
    end
  end

  // Write strobe issued once per completed write data byte.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_pulse_reg <= 1'b0;
      wr_addr_reg  <= 15'h0000;
      wr_data_reg  <= 8'h00;
    end else begin
      wr_pulse_reg <= !csn_s2 && !srst_active && sclk_rise && !is_read_reg
                      && phase_reg == scf_pkg::SCF_DATA
                      && bit_cnt_reg == scf_pkg::DATA_LAST_BIT;
      if (sclk_rise) begin
        wr_addr_reg <= addr_reg;
        wr_data_reg <= {shin_reg[6:0], sdi_s2};
      end
    end
  end

  // Read shifter: the output only moves after a serial clock fall, so the host
  // samples a settled bit on the next rise. The first fall of each byte loads
  // it from the working address; the other seven falls shift it.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shout_reg  <= 8'h00;
      spi_sdo_oe <= 1'b0;
    end else if (csn_s2 || srst_active) begin
      shout_reg  <= 8'h00;
      spi_sdo_oe <= 1'b0;
    end else if (sclk_rise && phase_reg == scf_pkg::SCF_INSTR
                 && bit_cnt_reg == scf_pkg::INSTR_LAST_BIT) begin
      spi_sdo_oe <= instr_read;
    end else if (sclk_fall && phase_reg == scf_pkg::SCF_DATA
                 && bit_cnt_reg == 5'h00) begin
      shout_reg <= read_byte(addr_reg);
    end else if (sclk_fall && phase_reg == scf_pkg::SCF_DATA) begin
      shout_reg <= {shout_reg[6:0], 1'b0};
    end
  end

  assign spi_sdo = shout_reg[7] & spi_sdo_oe;

endmodule : scf_regs

`default_nettype wire

/* hw/scf_pkg.sv */
// Package of the SPI front configuration register bank: offsets, field
// positions, reset values and timing counts.
// Assumes a single 100 MHz system clock shared by every user of the package.
package scf_pkg;

  // ---------------------------------------------------------------------------
  // Register byte addresses on the serial port
  // ---------------------------------------------------------------------------
  localparam logic [14:0] ADDR_IF_CFG  = 15'h0000;  // Interface configuration.
  localparam logic [14:0] ADDR_PWR_CFG = 15'h0002;  // Device power configuration.
  localparam logic [14:0] ADDR_ID_LO   = 15'h000C;  // Maker code, bits 7:0.
  localparam logic [14:0] ADDR_ID_HI   = 15'h000D;  // Maker code, bits 15:8.
  localparam logic [14:0] ADDR_USR_CFG = 15'h0010;  // User streaming configuration.

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int          BIT_SOFT_RESET = 7;
  localparam int          BIT_ASCEND     = 5;
  localparam int          BIT_SEP_OUT    = 4;
  localparam int          BIT_ADDR_HOLD  = 0;
  localparam logic [7:0]  RST_IF_CFG     = 8'h30;
  localparam logic [7:0]  RST_PWR_CFG    = 8'h00;
  localparam logic [7:0]  RST_USR_CFG    = 8'h00;
  localparam logic [1:0]  MODE_NORMAL    = 2'h0;
  localparam logic [1:0]  MODE_PWR_DOWN  = 2'h3;

  // ---------------------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------------------
  localparam logic [4:0]  INSTR_LAST_BIT = 5'h0F;   // 16-bit instruction phase.
  localparam logic [4:0]  DATA_LAST_BIT  = 5'h07;   // 8-bit data bytes.
  localparam int          BIT_READ       = 15;      // Read/write flag in instruction.

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int          CLK_PERIOD_NS     = 10;
  localparam int          SOFT_RESET_NS     = 750;
  // Longest internal reset, rounded down to whole cycles.
  localparam int          SOFT_RESET_CYCLES = SOFT_RESET_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  SOFT_RESET_COUNT  = 8'(SOFT_RESET_CYCLES);

  typedef enum logic {
    SCF_INSTR,
    SCF_DATA
  } scf_phase_t;

endpackage : scf_pkg

/* tb/scf_regs_asserts.sv */
// Checker for the serial front of scf_regs.
// Bound to every scf_regs instance and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module scf_regs_asserts (
  input wire logic       clk,             // System clock.
  input wire logic       rstn,            // Reset, active low.
  input wire logic       spi_csn,         // Chip select.
  input wire logic       spi_sclk,        // Serial clock.
  input wire logic       spi_sdo,         // Read data.
  input wire logic       spi_sdo_oe,      // Read data enable.
  input wire logic       chip_soft_reset, // Internal reset.
  input wire logic [1:0] power_mode,      // Power mode field.
  input wire logic       full_power_down  // Power down flag.
);
  logic [7:0] srst_cnt_reg;  // Cycles of soft reset so far.

  // Counts the length of each soft reset pulse.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) srst_cnt_reg <= 8'h00;
    else srst_cnt_reg <= chip_soft_reset ? srst_cnt_reg + 8'h01 : 8'h00;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  a_pd_decode: assert property (full_power_down == (power_mode == 2'h3))
    else $error("power down flag does not follow mode");
  a_srst_length: assert property ($fell(chip_soft_reset) |-> srst_cnt_reg == scf_pkg::SOFT_RESET_COUNT)
    else $error("soft reset pulse length wrong");
  a_srst_self_clears: assert property (srst_cnt_reg <= scf_pkg::SOFT_RESET_COUNT)
    else $error("soft reset did not clear itself");
  a_srst_clears_regs: assert property (chip_soft_reset && $past(chip_soft_reset) |-> power_mode == 2'h0)
    else $error("power mode kept during soft reset");
  a_srst_port_idle: assert property (chip_soft_reset |-> !spi_sdo_oe)
    else $error("read output active during soft reset");
  a_sdo_gated: assert property (!spi_sdo_oe |-> !spi_sdo)
    else $error("read output not quiet while disabled");
  a_oe_in_frame: assert property ($rose(spi_sdo_oe) |-> !spi_csn)
    else $error("read output enabled outside a frame");
  a_oe_release: assert property (spi_csn [*4] |-> !spi_sdo_oe)
    else $error("read output kept after frame end");
  a_sdo_on_fall: assert property (spi_sdo_oe && $past(spi_sdo_oe) && $changed(spi_sdo) |-> !spi_sclk)
    else $error("read data moved while serial clock high");

  c_soft_reset: cover property ($fell(chip_soft_reset));
  c_power_down: cover property ($rose(full_power_down));
  c_read_frame: cover property ($rose(spi_sdo_oe));
endmodule : scf_regs_asserts

bind scf_regs scf_regs_asserts u_chk (.clk(clk), .rstn(rstn), .spi_csn(spi_csn),
  .spi_sclk(spi_sclk), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
  .chip_soft_reset(chip_soft_reset), .power_mode(power_mode),
  .full_power_down(full_power_down));
`default_nettype wire

/* tb/scf_host_model.sv */
// Serial host model sending mode 0 frames, MSB first.
// Assumes the 100 MHz bench clock; five clocks per half bit.
`timescale 1ns/1ps
`default_nettype none
module scf_host_model (
  input  wire logic clk,      // Bench clock.
  output var  logic spi_sclk, // Serial clock, idle low.
  output var  logic spi_csn,  // Chip select, active low.
  output var  logic spi_sdi,  // Serial data to device.
  input  wire logic spi_sdo   // Read data from device.
);
  // Idle levels at time zero.
  initial begin
    spi_sclk = 1'b0;
    spi_csn  = 1'b1;
    spi_sdi  = 1'b0;
  end

  // Sends one frame of n bytes; read data is taken from spi_sdo only.
  task automatic frame(input logic [15:0] ins, input int n, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [31:0] sh;
    sh = {ins, wd};
    rd = 16'h0000;
    @(posedge clk) #1 spi_csn = 1'b0;
    for (int i = 0; i < 16 + 8 * n; i++) begin
      spi_sdi = sh[31];
      sh = {sh[30:0], 1'b0};
      repeat (5) @(posedge clk);
      #1 spi_sclk = 1'b1;
      if (i >= 16) rd = {rd[14:0], spi_sdo};
      repeat (5) @(posedge clk);
      #1 spi_sclk = 1'b0;
    end
    repeat (5) @(posedge clk);
    #1 spi_csn = 1'b1;
    spi_sdi = ~spi_sdi;
    repeat (6) @(posedge clk);
    // Stays quiet while the internal reset runs.
    if (ins == 16'h0000 && wd[15]) repeat (80) @(posedge clk);
  endtask : frame
endmodule : scf_host_model
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for scf_regs through its serial port.
// Assumes scf_host_model as host and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [15:0] CODE = 16'h5A3C;  // Arbitrary maker code.
  logic        clk  = 1'b0;
  logic        rstn = 1'b0;
  logic        sclk, csn, sdi, sdo, sdo_oe, srst, pd;
  logic [1:0]  pmode, mv;
  logic [15:0] rdv;
  int          error_cnt = 0;
  int          n_checks  = 0;

  // Free running 100 MHz clock.
  always #5 clk = ~clk;

  scf_regs #(.MAKER_CODE(CODE)) dut (.clk(clk), .rstn(rstn), .spi_sclk(sclk),
    .spi_csn(csn), .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe),
    .chip_soft_reset(srst), .power_mode(pmode), .full_power_down(pd));
  scf_host_model host (.clk(clk), .spi_sclk(sclk), .spi_csn(csn), .spi_sdi(sdi),
    .spi_sdo(sdo));

  // Compares one result and counts it.
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Register write and read frames.
  task automatic wr(input logic [14:0] a, input int n, input logic [15:0] d);
    logic [15:0] unused;
    host.frame({1'b0, a}, n, d, unused);
  endtask : wr
  task automatic rd(input logic [14:0] a, input int n, output logic [15:0] d);
    host.frame({1'b1, a}, n, 16'h0000, d);
  endtask : rd

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  // Cuts a hang short.
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    stop_test();
  end

  // Main sequence.
  initial begin
    repeat (2) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (4) @(posedge clk);
    rd(15'h0000, 1, rdv); chk("if_cfg", 16'h0030, rdv);
    rd(15'h000C, 2, rdv); chk("code up", {CODE[7:0], CODE[15:8]}, rdv);
    wr(15'h000C, 2, 16'h0000);
    rd(15'h000C, 2, rdv); chk("code kept", {CODE[7:0], CODE[15:8]}, rdv);
    rd(15'h0005, 1, rdv); chk("unmapped", 16'h0000, rdv);
    wr(15'h0000, 1, 16'h1000);
    rd(15'h0000, 1, rdv); chk("if_cfg dn", 16'h0010, rdv);
    rd(15'h000D, 2, rdv); chk("code down", CODE, rdv);
    wr(15'h0003, 2, 16'h0001);
    chk("mode dn", 16'h0001, {14'h0000, pmode});
    wr(15'h0000, 1, 16'h3000);
    wr(15'h0001, 2, 16'h0002);
    chk("mode up", 16'h0002, {14'h0000, pmode});
    for (int m = 0; m < 4; m++) begin
      mv = m[1:0];
      wr(15'h0002, 1, {6'h00, mv, 8'h00});
      chk("mode", {14'h0000, mv}, {14'h0000, pmode});
      chk("pd", {15'h0000, mv == 2'h3}, {15'h0000, pd});
    end
    wr(15'h0010, 1, 16'h0100);
    wr(15'h0002, 2, 16'h0300);
    chk("mode hold", 16'h0000, {14'h0000, pmode});
    rd(15'h0010, 2, rdv); chk("usr hold", 16'h0101, rdv);
    wr(15'h0002, 1, 16'h0300);
    wr(15'h0000, 1, 16'h8000);
    chk("srst", 16'h0000, {15'h0000, srst});
    chk("mode srst", 16'h0000, {14'h0000, pmode});
    chk("pd srst", 16'h0000, {15'h0000, pd});
    rd(15'h0000, 1, rdv); chk("if_cfg srst", 16'h0030, rdv);
    rd(15'h0010, 1, rdv); chk("usr srst", 16'h0000, rdv);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
